// file: hdl/gsmsr_regs.vh
`ifndef GSMSR_REGS_VH
`define GSMSR_REGS_VH
// Mailbox identifiers
`define GSMSR_MB_STATUS   8'h00
`define GSMSR_MB_MEAS     8'h01
`define GSMSR_MB_RESULT   8'h02
`define GSMSR_MB_RAW      8'h03
`define GSMSR_MB_ENV      8'h05
`define GSMSR_MB_LIMIT_CROSSING_IRQ_ENABLE   8'h10
`define GSMSR_MB_BASE     8'h11
`define GSMSR_MB_FAULT    8'hE0
`define GSMSR_MB_START    8'hF4
`define GSMSR_MB_SWRST    8'hFF
// Data bytes expected by each writable mailbox
`define GSMSR_SZ_MEAS     3'h1
`define GSMSR_SZ_ENV      3'h4
`define GSMSR_SZ_LIMIT_CROSSING_IRQ_ENABLE   3'h5
`define GSMSR_SZ_BASE     3'h2
`define GSMSR_SZ_START    3'h0
`define GSMSR_SZ_SWRST    3'h4
`define GSMSR_SZ_NONE     3'h7
// Status register fields
`define GSMSR_ST_FW       7
`define GSMSR_ST_APP      4
`define GSMSR_ST_READY    3
`define GSMSR_ST_ERR      0
// Measurement config fields
`define GSMSR_MC_MODE_HI  6
`define GSMSR_MC_MODE_LO  4
`define GSMSR_MC_INT      3
`define GSMSR_MC_THR      2
`define GSMSR_MC_WMASK    8'h7C
`define GSMSR_MODE_IDLE   3'h0
`define GSMSR_MODE_1S     3'h1
`define GSMSR_MODE_10S    3'h2
`define GSMSR_MODE_60S    3'h3
`define GSMSR_MODE_RAW    3'h4
// Fault cause bits
`define GSMSR_FC_BADWR    0
`define GSMSR_FC_BADRD    1
`define GSMSR_FC_BADMODE  2
`define GSMSR_FC_OVR      3
`define GSMSR_FC_HTR      4
`define GSMSR_FC_HPWR     5
// Reset values
`define GSMSR_MEAS_RST    8'h00
`define GSMSR_FAULT_RST   8'h00
`define GSMSR_THR_LO_RST  16'h0000
`define GSMSR_THR_HI_RST  16'hFFFF
`define GSMSR_HYST_RST    8'h00
`define GSMSR_SWRST_KEY   32'h11E5728A
`define GSMSR_I2C_ADDR    7'h5A
// Timing
`define GSMSR_CLK_KHZ     100000
`define GSMSR_RAW_MS      250
`define GSMSR_1S_MS       1000
`define GSMSR_10S_MS      10000
`define GSMSR_60S_MS      60000
`endif

// file: hdl/gsmsr_i2c.v
`timescale 1ns/10ps
`include "gsmsr_regs.vh"
module gsmsr_i2c (
  input  wire       clk,      // System clock
  input  wire       rst,      // Synchronous reset
  input  wire       scl_pin,  // Raw SCL level
  input  wire       sda_pin,  // Raw SDA level
  input  wire [6:0] dev_addr, // Own 7-bit address
  input  wire [7:0] rdata,    // Byte to send on read
  output reg        sda_oe,   // Pull SDA low
  output reg        wstrb,    // Write byte received
  output reg  [7:0] wdata,    // Received byte
  output reg        wend,     // Write transaction ended
  output reg        rstart,   // Read transaction addressed
  output reg        rtake     // Read byte loaded
);
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_AACK = 3'h2;
  localparam S_WDAT = 3'h3;
  localparam S_WACK = 3'h4;
  localparam S_RDAT = 3'h5;
  localparam S_RACK = 3'h6;

  reg       scl_m, scl_s, scl_d;
  reg       sda_m, sda_s, sda_d;
  reg [2:0] state;
  reg [3:0] cnt;
  reg [7:0] sh;
  reg       rw;
  reg       acked;

  // Edge and bus condition detection on synchronised levels
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start    = scl_s & scl_d & sda_d & ~sda_s;
  wire stop     = scl_s & scl_d & ~sda_d & sda_s;

  // Byte-level slave engine
  always @(posedge clk) begin
    if (rst) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      state  <= S_IDLE;
      cnt    <= 4'h0;
      sh     <= 8'h00;
      rw     <= 1'b0;
      acked  <= 1'b0;
      sda_oe <= 1'b0;
      wstrb  <= 1'b0;
      wdata  <= 8'h00;
      wend   <= 1'b0;
      rstart <= 1'b0;
      rtake  <= 1'b0;
    end else begin
      scl_m  <= scl_pin;
      scl_s  <= scl_m;
      scl_d  <= scl_s;
      sda_m  <= sda_pin;
      sda_s  <= sda_m;
      sda_d  <= sda_s;
      wstrb  <= 1'b0;
      wend   <= 1'b0;
      rstart <= 1'b0;
      rtake  <= 1'b0;
      if (start | stop) begin
        wend   <= (state == S_WDAT) | (state == S_WACK);
        sda_oe <= 1'b0;
        cnt    <= 4'h0;
        state  <= start ? S_ADDR : S_IDLE;
      end else if (scl_rise) begin
        case (state)
          S_ADDR, S_WDAT: begin
            sh  <= {sh[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          S_RDAT: cnt <= cnt + 4'h1;
          S_RACK: acked <= ~sda_s;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          S_ADDR: if (cnt == 4'h8) begin
            if (sh[7:1] == dev_addr) begin
              state  <= S_AACK;
              sda_oe <= 1'b1;
              rw     <= sh[0];
              rstart <= sh[0];
            end else begin
              state <= S_IDLE;
            end
          end
          S_AACK, S_WACK, S_RACK: begin
            cnt <= 4'h0;
            if (rw && (state != S_RACK || acked)) begin
              sh     <= rdata;
              rtake  <= 1'b1;
              sda_oe <= ~rdata[7];
              state  <= S_RDAT;
            end else begin
              sda_oe <= 1'b0;
              state  <= rw ? S_IDLE : S_WDAT;
            end
          end
          S_WDAT: if (cnt == 4'h8) begin
            wdata  <= sh;
            wstrb  <= 1'b1;
            sda_oe <= 1'b1;
            state  <= S_WACK;
          end
          S_RDAT: begin
            if (cnt == 4'h8) begin
              sda_oe <= 1'b0;
              state  <= S_RACK;
            end else begin
              sh     <= {sh[6:0], 1'b0};
              sda_oe <= ~sh[6];
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule // gsmsr_i2c

// file: hdl/gsmsr_top.v
`timescale 1ns/10ps
`include "gsmsr_regs.vh"
module gsmsr_top #(
  parameter QUARTER_CYCLES = `GSMSR_RAW_MS * `GSMSR_CLK_KHZ // 250 ms count
) (
  input  wire        CLOCK,            // System clock, 100 MHz
  input  wire        SRST,             // Synchronous reset, active high
  input  wire        SCL,              // Serial clock pin
  input  wire        SDA_IN,           // Serial data pin level
  output wire        SDA_OUT,          // Serial data drive value
  output wire        SDA_OE,           // Serial data drive enable
  input  wire        ADDR_SEL,         // Address select pin
  input  wire        FW_APP_MODE,      // Firmware in application mode
  input  wire        APP_PRESENT,      // Application image valid
  input  wire [15:0] SAMPLE_CO2,       // Current eCO2 value
  input  wire [15:0] SAMPLE_TVOC,      // Current TVOC value
  input  wire [15:0] SAMPLE_RAW,       // Current raw ADC value
  input  wire        OVERRANGE_EVT,    // Sensing element over range
  input  wire        HEATER_FAULT_EVT, // Heater fault event
  input  wire        HEATER_POWER_EVT, // Heater_power_flag event
  output reg         MEAS_TICK,        // Sample taken pulse
  output reg         IRQ_OUT_N         // Interrupt, active low
);
  localparam integer Q1I  = `GSMSR_1S_MS / `GSMSR_RAW_MS;
  localparam integer Q10I = `GSMSR_10S_MS / `GSMSR_RAW_MS;
  localparam integer Q60I = `GSMSR_60S_MS / `GSMSR_RAW_MS;

  reg        fw_m, fw, app_m, app, adr_m, adr;
  reg  [7:0] meas_cfg, fault, mbox;
  reg        data_ready, irq_pend, swr;
  reg [15:0] co2, tvoc, raw, thr_lo, thr_hi;
  reg  [7:0] thr_hyst, icnt;
  reg  [1:0] zone;
  reg  [2:0] wcnt, ridx;
  reg [39:0] wbuf;
  reg [31:0] qcnt;
  reg  [7:0] rdata, next_fault;
  reg        next_ready, next_irq;
  wire       wstrb, wend, rstart, rtake;
  wire [7:0] wdata;

  // Expected data length of a writable mailbox
  function [2:0] wsize(input [7:0] mb);
    case (mb)
      `GSMSR_MB_MEAS:   wsize = `GSMSR_SZ_MEAS;
      `GSMSR_MB_ENV:    wsize = `GSMSR_SZ_ENV;
      `GSMSR_MB_LIMIT_CROSSING_IRQ_ENABLE: wsize = `GSMSR_SZ_LIMIT_CROSSING_IRQ_ENABLE;
      `GSMSR_MB_BASE:   wsize = `GSMSR_SZ_BASE;
      `GSMSR_MB_START:  wsize = `GSMSR_SZ_START;
      `GSMSR_MB_SWRST:  wsize = `GSMSR_SZ_SWRST;
      default:          wsize = `GSMSR_SZ_NONE;
    endcase
  endfunction

  // Mailboxes that answer a read
  function rvalid(input [7:0] mb);
    rvalid = (mb == `GSMSR_MB_STATUS) | (mb == `GSMSR_MB_MEAS) |
             (mb == `GSMSR_MB_RESULT) | (mb == `GSMSR_MB_RAW) |
             (mb == `GSMSR_MB_FAULT);
  endfunction

  // Sample interval in 250 ms steps for a drive mode
  function [7:0] quarters(input [2:0] m);
    case (m)
      `GSMSR_MODE_1S:  quarters = Q1I[7:0];
      `GSMSR_MODE_10S: quarters = Q10I[7:0];
      `GSMSR_MODE_60S: quarters = Q60I[7:0];
      default:         quarters = 8'h01;
    endcase
  endfunction

  // Threshold band: 0 low, 1 middle, 2 high; edges keep the old band
  function [1:0] zone_of(input [15:0] c, input [15:0] lo, input [15:0] hi,
                         input [7:0] h, input [1:0] cur);
    reg [16:0] ch, lh;
    begin
      ch = {1'b0, c} + {9'h000, h};
      lh = {1'b0, lo} + {9'h000, h};
      if (ch < {1'b0, lo})
        zone_of = 2'h0;
      else if ({1'b0, c} > {1'b0, hi} + {9'h000, h})
        zone_of = 2'h2;
      else if ({1'b0, c} > lh && ch < {1'b0, hi})
        zone_of = 2'h1;
      else
        zone_of = cur;
    end
  endfunction

  gsmsr_i2c u_i2c (
    .clk      (CLOCK),
    .rst      (SRST),
    .scl_pin  (SCL),
    .sda_pin  (SDA_IN),
    .dev_addr (`GSMSR_I2C_ADDR | {6'h00, adr}),
    .rdata    (rdata),
    .sda_oe   (SDA_OE),
    .wstrb    (wstrb),
    .wdata    (wdata),
    .wend     (wend),
    .rstart   (rstart),
    .rtake    (rtake)
  );
  assign SDA_OUT = 1'b0;

  // Decoded events
  wire [2:0] mode    = meas_cfg[`GSMSR_MC_MODE_HI:`GSMSR_MC_MODE_LO];
  wire [2:0] want    = wsize(mbox);
  wire       wr_ok   = (wcnt == 3'h1) ? (want != `GSMSR_SZ_NONE ||
                       rvalid(mbox)) : (want == wcnt - 3'h1);
  wire       wr_bad  = wend & (wcnt != 3'h0) & ~wr_ok;
  wire       wr_do   = wend & wr_ok & (wcnt != 3'h1);
  wire       mode_wr = wr_do & (mbox == `GSMSR_MB_MEAS);
  wire       mode_bad = mode_wr &
                        (wbuf[6:4] > `GSMSR_MODE_RAW);
  wire       first_rd = rtake & (ridx == 3'h0);
  wire       res_rd  = first_rd & (mbox == `GSMSR_MB_RESULT);
  wire       running = (mode != `GSMSR_MODE_IDLE) & fw;
  wire       qtick   = running & (qcnt == QUARTER_CYCLES - 1);
  wire       sample  = qtick & (icnt == quarters(mode) - 8'h01);
  wire [1:0] new_zone = zone_of(SAMPLE_CO2, thr_lo, thr_hi, thr_hyst, zone);
  wire       thr_hit = new_zone != zone;
  wire [7:0] status  = {fw, 2'h0, app, data_ready, 2'h0,
                        |fault};

  // Sticky flags: the clear is applied first so a same-cycle set wins
  always @* begin
    next_fault = fault;
    next_ready = data_ready;
    next_irq   = irq_pend;
    if (first_rd && mbox == `GSMSR_MB_FAULT)
      next_fault = `GSMSR_FAULT_RST;
    if (res_rd) begin
      next_ready = 1'b0;
      next_irq   = 1'b0;
    end
    next_fault[`GSMSR_FC_BADWR]   = next_fault[`GSMSR_FC_BADWR] | wr_bad;
    next_fault[`GSMSR_FC_BADRD]   = next_fault[`GSMSR_FC_BADRD] |
                                    (first_rd & ~rvalid(mbox));
    next_fault[`GSMSR_FC_BADMODE] = next_fault[`GSMSR_FC_BADMODE] | mode_bad;
    next_fault[`GSMSR_FC_OVR]     = next_fault[`GSMSR_FC_OVR] | OVERRANGE_EVT;
    next_fault[`GSMSR_FC_HTR]     = next_fault[`GSMSR_FC_HTR] |
                                    HEATER_FAULT_EVT;
    next_fault[`GSMSR_FC_HPWR]    = next_fault[`GSMSR_FC_HPWR] |
                                    HEATER_POWER_EVT;
    if (sample) begin
      next_ready = 1'b1;
      if (meas_cfg[`GSMSR_MC_INT] &&
          (!meas_cfg[`GSMSR_MC_THR] || thr_hit))
        next_irq = 1'b1;
    end
  end

  // Read data for the addressed mailbox and byte position
  always @* begin
    rdata = 8'h00;
    case (mbox)
      `GSMSR_MB_STATUS: rdata = status;
      `GSMSR_MB_MEAS:   rdata = meas_cfg;
      `GSMSR_MB_FAULT:  rdata = fault;
      `GSMSR_MB_RAW:    rdata = ridx[0] ? raw[7:0] : raw[15:8];
      `GSMSR_MB_RESULT:
        case (ridx)
          3'h0:    rdata = co2[15:8];
          3'h1:    rdata = co2[7:0];
          3'h2:    rdata = tvoc[15:8];
          3'h3:    rdata = tvoc[7:0];
          3'h4:    rdata = status;
          3'h5:    rdata = fault;
          3'h6:    rdata = raw[15:8];
          default: rdata = raw[7:0];
        endcase
      default: rdata = 8'h00;
    endcase
  end

  // Pin synchronisers and transaction tracking
  always @(posedge CLOCK) begin
    if (SRST) begin
      {fw_m, fw, app_m, app, adr_m, adr} <= 6'h00;
      mbox <= `GSMSR_MB_STATUS;
      wcnt <= 3'h0;
      ridx <= 3'h0;
      wbuf <= 40'h0000000000;
      swr  <= 1'b0;
    end else begin
      fw_m  <= FW_APP_MODE;
      fw    <= fw_m;
      app_m <= APP_PRESENT;
      app   <= app_m;
      adr_m <= ADDR_SEL;
      adr   <= adr_m;
      swr   <= wr_do & (mbox == `GSMSR_MB_SWRST) &
               (wbuf[31:0] == `GSMSR_SWRST_KEY);
      if (wstrb) begin
        if (wcnt == 3'h0)
          mbox <= wdata;
        else
          wbuf <= {wbuf[31:0], wdata};
        if (wcnt != 3'h7)
          wcnt <= wcnt + 3'h1;
      end
      if (wend)
        wcnt <= 3'h0;
      if (rstart)
        ridx <= 3'h0;
      else if (rtake)
        ridx <= ridx + 3'h1;
    end
  end

  // Registers, sample timer and interrupt pin; software reset acts here
  always @(posedge CLOCK) begin
    if (SRST | swr) begin
      meas_cfg   <= `GSMSR_MEAS_RST;
      fault      <= `GSMSR_FAULT_RST;
      data_ready <= 1'b0;
      irq_pend   <= 1'b0;
      thr_lo     <= `GSMSR_THR_LO_RST;
      thr_hi     <= `GSMSR_THR_HI_RST;
      thr_hyst   <= `GSMSR_HYST_RST;
      zone       <= 2'h1;
      co2        <= 16'h0000;
      tvoc       <= 16'h0000;
      raw        <= 16'h0000;
      qcnt       <= 32'h00000000;
      icnt       <= 8'h00;
      MEAS_TICK  <= 1'b0;
      IRQ_OUT_N  <= 1'b1;
    end else begin
      fault      <= next_fault & 8'h3F;
      data_ready <= next_ready;
      irq_pend   <= next_irq;
      IRQ_OUT_N  <= ~(next_irq & meas_cfg[`GSMSR_MC_INT]);
      MEAS_TICK  <= sample;
      if (mode_wr && !mode_bad)
        meas_cfg <= wbuf[7:0] & `GSMSR_MC_WMASK;
      if (wr_do && mbox == `GSMSR_MB_LIMIT_CROSSING_IRQ_ENABLE) begin
        thr_lo   <= wbuf[39:24];
        thr_hi   <= wbuf[23:8];
        thr_hyst <= wbuf[7:0];
      end
      if (!running || mode_wr) begin
        qcnt <= 32'h00000000;
        icnt <= 8'h00;
      end else if (qtick) begin
        qcnt <= 32'h00000000;
        icnt <= sample ? 8'h00 : icnt + 8'h01;
      end else begin
        qcnt <= qcnt + 32'h00000001;
      end
      if (sample) begin
        co2  <= SAMPLE_CO2;
        tvoc <= SAMPLE_TVOC;
        raw  <= SAMPLE_RAW;
        zone <= new_zone;
      end
    end
  end
endmodule // gsmsr_top

// file: sim/gsmsr_top_properties.sv
`timescale 1ns/10ps
// Port-level checks for the gas sensor register block
module gsmsr_props #(
  parameter QUARTER_CYCLES = 50 // Clocks per 250 ms step
) (
  input wire CLOCK,       // System clock
  input wire SRST,        // Synchronous reset
  input wire SCL,         // Serial clock pin
  input wire SDA_IN,      // Serial data level
  input wire SDA_OE,      // Device pulls data low
  input wire FW_APP_MODE, // Firmware state
  input wire MEAS_TICK,   // Sample pulse
  input wire IRQ_OUT_N    // Interrupt, active low
);
  logic [31:0] gap;   // Clocks since last sample pulse
  logic [4:0]  quiet; // Clocks since the bus last moved
  logic        scl_q; // Delayed clock pin
  logic        sda_q; // Delayed data pin
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // Helper counters for sample spacing and bus activity
  always @(posedge CLOCK) begin
    scl_q <= SCL;
    sda_q <= SDA_IN;
    if (SRST) gap <= 32'hFFFFFFFF;
    else if (MEAS_TICK) gap <= 32'h1;
    else if (gap != 32'hFFFFFFFF) gap <= gap + 32'h1;
    if (SRST || SCL != scl_q || SDA_IN != sda_q) quiet <= 5'h0;
    else if (quiet != 5'h1F) quiet <= quiet + 5'h1;
  end
  // Firmware held in boot state for a while
  sequence fw_off_run;
    !FW_APP_MODE [*6];
  endsequence
  // Serial bus moved recently
  sequence bus_recent;
    quiet < 5'd20;
  endsequence
  chk_tick_one_cycle: assert property (
    MEAS_TICK |=> !MEAS_TICK) else $error("Sample pulse too long");
  chk_tick_needs_fw: assert property (
    fw_off_run |-> !MEAS_TICK) else $error("Sample taken in boot state");
  chk_tick_spacing: assert property (
    MEAS_TICK |-> gap >= QUARTER_CYCLES) else $error("Samples too close");
  chk_irq_on_sample: assert property (
    $fell(IRQ_OUT_N) |-> ##[0:1]
      (MEAS_TICK || $past(MEAS_TICK) || $past(MEAS_TICK, 2)))
    else $error("Interrupt without a sample");
  chk_irq_release_bus: assert property (
    $rose(IRQ_OUT_N) |-> bus_recent) else $error("Interrupt released idly");
  chk_reset_outputs: assert property (
    @(posedge CLOCK) disable iff (1'b0)
    SRST |=> IRQ_OUT_N && !MEAS_TICK && !SDA_OE)
    else $error("Outputs active after reset");
  chk_sda_scl_low: assert property (
    $changed(SDA_OE) |-> !SCL) else $error("Data moved with clock high");
  chk_idle_release: assert property (
    quiet == 5'h1F && SCL |-> !SDA_OE) else $error("Data held on idle bus");
endmodule // gsmsr_props
bind gsmsr_top gsmsr_props #(.QUARTER_CYCLES(QUARTER_CYCLES)) u_gsmsr_props (
  .CLOCK(CLOCK), .SRST(SRST), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OE(SDA_OE),
  .FW_APP_MODE(FW_APP_MODE), .MEAS_TICK(MEAS_TICK), .IRQ_OUT_N(IRQ_OUT_N)
);

// file: sim/gsmsr_host.sv
`timescale 1ns/10ps
// Host processor model: serial bus master behind a pull-up
module gsmsr_host (
  input  wire SDA_OE,  // Device pulls data low
  input  wire SDA_OUT, // Device drive value
  output reg  SCL,     // Serial clock
  output wire SDA_IN   // Resolved data line
);
  reg       rel;  // Host releases data line
  reg [6:0] addr; // Target address
  reg       s;    // Scratch sample
  // Open-drain data wire with pull-up
  assign SDA_IN = rel & (SDA_OE ? SDA_OUT : 1'b1);
  initial begin
    SCL = 1'b1;
    rel = 1'b1;
    addr = 7'h5A;
  end
  // One bit: data set mid-low, sampled at the rising clock
  task bit_io(input logic b, output logic v);
    begin
      #31.25 rel = b;
      #31.25 SCL = 1'b1;
      v = SDA_IN;
      #62.5 SCL = 1'b0;
    end
  endtask
  // Start or repeated start
  task start;
    begin
      #31.25 rel = 1'b1;
      #31.25 SCL = 1'b1;
      #62.5 rel = 1'b0;
      #62.5 SCL = 1'b0;
    end
  endtask
  // Stop, clock left standing high
  task stop;
    begin
      #31.25 rel = 1'b0;
      #31.25 SCL = 1'b1;
      #62.5 rel = 1'b1;
      #62.5;
    end
  endtask
  // Byte out, MSB first, then the device's acknowledge
  task put(input logic [7:0] b, output logic ack);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = ~s;
    end
  endtask
  // Byte in, host refuses the last one
  task get(input logic last, output logic [7:0] b);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) bit_io(1'b1, b[i]);
      bit_io(last, s);
    end
  endtask
  // Mailbox write: id then every data byte
  task wr(input logic [7:0] id, input logic [7:0] d[$], output logic ok);
    logic   a;
    integer i;
    begin
      start;
      put({addr, 1'b0}, ok);
      put(id, a);
      for (i = 0; i < d.size(); i = i + 1) put(d[i], a);
      stop;
    end
  endtask
  // Mailbox read: pointer write, repeated start, n bytes
  task rd(input logic [7:0] id, input integer n, output logic [7:0] q[$],
          output logic ok);
    logic       a;
    logic [7:0] b;
    integer     i;
    begin
      q = {};
      start;
      put({addr, 1'b0}, ok);
      put(id, a);
      start;
      put({addr, 1'b1}, a);
      for (i = 0; i < n; i = i + 1) begin
        get(i == n - 1, b);
        q.push_back(b);
      end
      stop;
    end
  endtask
endmodule // gsmsr_host

// file: sim/gsmsr_top_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the gas sensor register block
module gsmsr_top_tb;
  localparam int Q = 50;
  logic        CLOCK, SRST, SCL, SDA_IN, SDA_OUT, SDA_OE, ADDR_SEL;
  logic        FW_APP_MODE, APP_PRESENT, MEAS_TICK, IRQ_OUT_N;
  logic        OVERRANGE_EVT, HEATER_FAULT_EVT, HEATER_POWER_EVT;
  logic [15:0] SAMPLE_CO2, SAMPLE_TVOC, SAMPLE_RAW;
  logic [7:0]  q[$];
  logic        ok;
  int          n_errors, samples_checked, ticks, t0, t1, i;
  int          per[4] = '{4, 40, 240, 1};
  gsmsr_top #(.QUARTER_CYCLES(Q)) u_gsmsr_top (
    .CLOCK(CLOCK), .SRST(SRST), .SCL(SCL), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ADDR_SEL(ADDR_SEL),
    .FW_APP_MODE(FW_APP_MODE), .APP_PRESENT(APP_PRESENT),
    .SAMPLE_CO2(SAMPLE_CO2), .SAMPLE_TVOC(SAMPLE_TVOC),
    .SAMPLE_RAW(SAMPLE_RAW), .OVERRANGE_EVT(OVERRANGE_EVT),
    .HEATER_FAULT_EVT(HEATER_FAULT_EVT),
    .HEATER_POWER_EVT(HEATER_POWER_EVT), .MEAS_TICK(MEAS_TICK),
    .IRQ_OUT_N(IRQ_OUT_N)
  );
  gsmsr_host u_gsmsr_host (
    .SDA_OE(SDA_OE), .SDA_OUT(SDA_OUT), .SCL(SCL), .SDA_IN(SDA_IN)
  );
  // Free-running system clock
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  // Count sample pulses
  always @(posedge CLOCK) begin
    if (MEAS_TICK === 1'b1) ticks <= ticks + 1;
  end
  task cyc(input int n);
    repeat (n) @(negedge CLOCK);
  endtask
  task check(input string nm, input logic [15:0] e, input logic [15:0] g);
    begin
      samples_checked++;
      if (g !== e) begin
        n_errors++;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task rd(input logic [7:0] id, input int n);
    u_gsmsr_host.rd(id, n, q, ok);
  endtask
  task wr1(input logic [7:0] id, input logic [7:0] d);
    u_gsmsr_host.wr(id, {d}, ok);
  endtask
  // Sensor fault events, all three together; a rising event waits for the
  // falling clock edge so that it always spans a sampling edge
  task evt(input logic v);
    begin
      if (v)
        cyc(1);
      OVERRANGE_EVT = v;
      HEATER_FAULT_EVT = v;
      HEATER_POWER_EVT = v;
    end
  endtask
  // Wait for the next sample pulse, bounded
  task wait_tick;
    int k;
    begin
      k = 0;
      cyc(1);
      while (MEAS_TICK !== 1'b1 && k < 30000) begin
        cyc(1);
        k++;
      end
      if (k == 30000) check("tick wait", 1, 0);
      t1 = $time / 10;
    end
  endtask
  task finish_test;
    begin
      $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Watchdog cuts a hung run short
  initial begin
    #1000000;
    n_errors++;
    finish_test;
  end
  // Main sequence of transfers and expectations
  initial begin
    SRST = 1'b1;
    ADDR_SEL = 1'b0;
    FW_APP_MODE = 1'b1;
    APP_PRESENT = 1'b1;
    SAMPLE_CO2 = 16'h1234;
    SAMPLE_TVOC = 16'h5678;
    SAMPLE_RAW = 16'h9ABC;
    evt(1'b0);
    cyc(12);
    SRST = 1'b0;
    cyc(4);
    for (i = 0; i < 4; i++) begin
      cyc(1);
      FW_APP_MODE = i[1];
      APP_PRESENT = i[0];
      cyc(4);
      rd(8'h00, 1);
      check("status", {i[1], 2'h0, i[0], 4'h0}, q[0]);
    end
    // Alternate address: the old address is refused, the new one answered
    ADDR_SEL = 1'b1;
    cyc(4);
    u_gsmsr_host.rd(8'h00, 1, q, ok);
    check("old addr ack", 0, ok);
    u_gsmsr_host.addr = 7'h5B;
    rd(8'h00, 1);
    check("alt addr ack", 1, ok);
    check("alt addr data", 8'h90, q[0]);
    u_gsmsr_host.addr = 7'h5A;
    cyc(1);
    ADDR_SEL = 1'b0;
    cyc(4);
    rd(8'h01, 1);
    check("meas reset", 8'h00, q[0]);
    check("idle ticks", 0, ticks);
    for (i = 1; i <= 4; i++) begin
      wr1(8'h01, {1'b0, i[2:0], 4'h0});
      wait_tick;
      t0 = t1;
      wait_tick;
      check("period", Q * per[i - 1], t1 - t0);
      check("irq disabled", 1, IRQ_OUT_N);
    end
    // Sample with interrupt enabled, then sampling stopped by boot state
    wr1(8'h01, 8'h18);
    wait_tick;
    FW_APP_MODE = 1'b0;
    cyc(4);
    check("irq on sample", 0, IRQ_OUT_N);
    t0 = ticks;
    rd(8'h00, 1);
    check("ready set", 8'h18, q[0]);
    rd(8'h02, 8);
    check("result co2", 16'h1234, {q[0], q[1]});
    check("result tvoc", 16'h5678, {q[2], q[3]});
    check("result raw", 16'h9ABC, {q[6], q[7]});
    check("irq release", 1, IRQ_OUT_N);
    rd(8'h03, 2);
    check("raw data", 16'h9ABC, {q[0], q[1]});
    rd(8'h00, 1);
    check("ready clear", 8'h10, q[0]);
    check("gated ticks", t0, ticks);
    // Reserved bits, refused mode, bad length, bad mailbox, sensor faults
    wr1(8'h01, 8'h0F);
    rd(8'h01, 1);
    check("reserved bits", 8'h0C, q[0]);
    wr1(8'h01, 8'h50);
    rd(8'h01, 1);
    check("mode kept", 8'h0C, q[0]);
    u_gsmsr_host.wr(8'h01, {8'h10, 8'h10}, ok);
    rd(8'h00, 1);
    check("error bit", 8'h11, q[0]);
    rd(8'hE0, 1);
    check("fault cause", 8'h05, q[0]);
    rd(8'hE0, 1);
    check("fault clear", 8'h00, q[0]);
    rd(8'h20, 1);
    check("bad mailbox", 8'h00, q[0]);
    rd(8'hE0, 1);
    check("bad read", 8'h03, q[0]);
    evt(1'b1);
    cyc(1);
    evt(1'b0);
    rd(8'hE0, 1);
    check("sensor faults", 8'h38, q[0]);
    // Software reset, then a reset in mid-run
    evt(1'b1);
    cyc(1);
    evt(1'b0);
    u_gsmsr_host.wr(8'hFF, {8'h11, 8'hE5, 8'h72, 8'h8A}, ok);
    rd(8'hE0, 1);
    check("swrst fault", 8'h00, q[0]);
    rd(8'h01, 1);
    check("swrst meas", 8'h00, q[0]);
    evt(1'b1);
    cyc(1);
    evt(1'b0);
    SRST = 1'b1;
    cyc(2);
    SRST = 1'b0;
    cyc(4);
    rd(8'hE0, 1);
    check("reset fault", 8'h00, q[0]);
    // Threshold gating: quiet inside the band, interrupt on crossing
    u_gsmsr_host.wr(8'h10, {8'h03, 8'hE8, 8'h07, 8'hD0, 8'h0A}, ok);
    cyc(1);
    SAMPLE_CO2 = 16'd1500;
    FW_APP_MODE = 1'b1;
    wr1(8'h01, 8'h1C);
    wait_tick;
    wait_tick;
    cyc(4);
    check("inside band", 1, IRQ_OUT_N);
    SAMPLE_CO2 = 16'd2500;
    wait_tick;
    cyc(4);
    check("band cross", 0, IRQ_OUT_N);
    finish_test;
  end
endmodule // gsmsr_top_tb
